// ### core/external_pin_interrupts.sv
// two-pin external interrupt controller with wishbone registers
//
// What this block does
// R1 - pins fire even when driven as outputs
// R2 - low level requests for whole low time
// R3 - edges recognised only while io clock runs
// R4 - low level detected without io clock
// R5 - deep sleep wake needs two watchdog samples
// R6 - wake on sampled level or held level
// R7 - level gone before start-up: wake, no request
// R8 - request needs global and pin enable
// R9 - pin sampled first; pulses over one clock caught
// R10 - source holds low until instruction completes
// R11 - line one sense bits 3:2 decode
// R12 - line zero sense bits 1:0 decode
// R13 - enable bit 7 line one, 6 line zero
// R14 - each line has its own vector request
// R15 - pending flag set on every detected edge
// R16 - pending, enable, global enable raise request
// R17 - pending cleared by vector entry or write one
// R18 - pending reads zero in low-level mode
// R19 - writing zero leaves pending unchanged
// R20 - edge compares current and previous sample
//
// The Wishbone register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "ext_irq_map.svh"

module external_pin_interrupts
  import ext_irq_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ext_irq_line_zero_i,
  input wire logic ext_irq_line_one_i,
  input wire logic gie_i,
  input wire logic io_clk_run_i,
  input wire logic vec_enter_zero_i,
  input wire logic vec_enter_one_i,
  input wire logic sleep_deep_i,
  input wire logic wdt_tick_i,
  input wire logic [1:0] startup_time_fuses_i,
  output logic irq_req_zero_o,
  output logic irq_req_one_o,
  output logic wake_o
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------

  // R20 previous versus current sample
  function automatic logic sense_hit(
    input logic [1:0] mode,
    input logic cur,
    input logic prv
  );
    logic hit;
    hit = 1'b0;
    case (sense_mode_t'(mode))
      SENSE_ANY: begin
        hit = cur ^ prv;
      end
      SENSE_FALL: begin
        hit = prv & ~cur;
      end
      SENSE_RISE: begin
        hit = cur & ~prv;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction

  function automatic logic is_level(
    input logic [1:0] mode
  );
    return sense_mode_t'(mode) == SENSE_LOW;
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] sense_ctrl_ff;
  logic [7:0] enable_ctrl_ff;
  logic [1:0] pend_ff;
  logic [1:0] samp_ff;
  logic [1:0] prev_ff;
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic req_zero_ff;
  logic req_one_ff;
  logic wake_ff;
  wake_state_t state_ff;
  logic [10:0] cnt_ff;

  logic [7:0] nxt_sense_ctrl;
  logic [7:0] nxt_enable_ctrl;
  logic [1:0] nxt_pend;
  logic [31:0] nxt_rdata;
  logic nxt_req_zero;
  logic nxt_req_one;
  logic nxt_wake;
  wake_state_t nxt_state;
  logic [10:0] nxt_cnt;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire bus_req;
  wire bus_wr;
  wire wr_lane0;
  wire sel_sense;
  wire sel_enable;
  wire sel_pend;
  wire sel_status;

  // single cycle answer, dropped the cycle after
  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign bus_wr = bus_req & wb_we_i;
  assign wr_lane0 = bus_wr & wb_sel_i[0];
  assign sel_sense = wb_adr_i == `OFS_SENSE_CTRL;
  assign sel_enable = wb_adr_i == `OFS_ENABLE_CTRL;
  assign sel_pend = wb_adr_i == `OFS_PENDING;
  assign sel_status = wb_adr_i == `OFS_STATUS;

  // ----------------------------------------------------------------
  // field views
  // ----------------------------------------------------------------
  wire [1:0] mode_zero;
  wire [1:0] mode_one;
  wire en_zero;
  wire en_one;
  wire lvl_zero;
  wire lvl_one;

  // R12 line zero sense field
  assign mode_zero = sense_ctrl_ff[`SENSE_ZERO_LSB +: 2];
  // R11 line one sense field
  assign mode_one = sense_ctrl_ff[`SENSE_ONE_LSB +: 2];
  // R13 per-line enable bits
  assign en_zero = enable_ctrl_ff[`BIT_LINE_ZERO];
  assign en_one = enable_ctrl_ff[`BIT_LINE_ONE];
  assign lvl_zero = is_level(mode_zero);
  assign lvl_one = is_level(mode_one);

  // ----------------------------------------------------------------
  // edge detection
  // ----------------------------------------------------------------
  wire edge_zero;
  wire edge_one;

  // R3 edges only while io clock runs
  // stale samples across a stop may flag one late edge
  assign edge_zero = io_clk_run_i
    & sense_hit(mode_zero, samp_ff[0], prev_ff[0]);
  assign edge_one = io_clk_run_i
    & sense_hit(mode_one, samp_ff[1], prev_ff[1]);

  // ----------------------------------------------------------------
  // level detection
  // ----------------------------------------------------------------
  wire low_zero;
  wire low_one;
  wire wake_low;
  wire lvl_req_zero;
  wire lvl_req_one;

  // R4 raw pin, no io clock needed
  // R1 pin read regardless of its direction
  assign low_zero = lvl_zero & en_zero & ~ext_irq_line_zero_i;
  assign low_one = lvl_one & en_one & ~ext_irq_line_one_i;
  assign wake_low = low_zero | low_one;

  // R2 request for as long as pin stays low
  // R7 masked while asleep; gone level never requests
  assign lvl_req_zero = low_zero & ~sleep_deep_i & ~wake_ff;
  assign lvl_req_one = low_one & ~sleep_deep_i & ~wake_ff;

  // ----------------------------------------------------------------
  // pending flags
  // ----------------------------------------------------------------
  wire [1:0] pend_set;
  wire [1:0] pend_clr;
  wire [1:0] pend_wr;

  // R15 set on each detected edge, never in level mode
  assign pend_set[0] = edge_zero & ~lvl_zero;
  assign pend_set[1] = edge_one & ~lvl_one;

  // R19 only ones in the write clear
  assign pend_wr[0] = wr_lane0 & sel_pend & wb_dat_i[`BIT_LINE_ZERO];
  assign pend_wr[1] = wr_lane0 & sel_pend & wb_dat_i[`BIT_LINE_ONE];

  // R17 vector entry or write one
  assign pend_clr[0] = pend_wr[0] | vec_enter_zero_i;
  assign pend_clr[1] = pend_wr[1] | vec_enter_one_i;

  // set beats a same-cycle clear
  // R18 level mode forces zero
  assign nxt_pend[0] = ~lvl_zero
    & ((pend_ff[0] & ~pend_clr[0]) | pend_set[0]);
  assign nxt_pend[1] = ~lvl_one
    & ((pend_ff[1] & ~pend_clr[1]) | pend_set[1]);

  // ----------------------------------------------------------------
  // control register writes
  // ----------------------------------------------------------------
  assign nxt_sense_ctrl = (wr_lane0 & sel_sense)
    ? wb_dat_i[7:0] : sense_ctrl_ff;
  assign nxt_enable_ctrl = (wr_lane0 & sel_enable)
    ? (wb_dat_i[7:0] & `ENABLE_CTRL_MASK) : enable_ctrl_ff;

  // ----------------------------------------------------------------
  // interrupt requests
  // ----------------------------------------------------------------

  // R8 global and pin enable both needed
  // R16 pending with enables raises request
  // R14 separate request per line
  assign nxt_req_zero = gie_i & en_zero & (pend_ff[0] | lvl_req_zero);
  assign nxt_req_one = gie_i & en_one & (pend_ff[1] | lvl_req_one);

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  wire [7:0] pend_view;
  wire [7:0] status_view;
  wire [7:0] rd_byte;

  assign pend_view = {pend_ff[1], pend_ff[0], 6'h00};
  assign status_view = {5'h00, wake_ff, samp_ff[1], samp_ff[0]};
  assign rd_byte = sel_sense ? sense_ctrl_ff
    : sel_enable ? enable_ctrl_ff
    : sel_pend ? pend_view
    : sel_status ? status_view
    : 8'h00;
  // unmapped reads give zero, writes are dropped
  assign nxt_rdata = (bus_req & ~wb_we_i)
    ? {24'h000000, rd_byte} : 32'h00000000;

  // ----------------------------------------------------------------
  // wake sequencer
  // ----------------------------------------------------------------
  wire [10:0] startup_cyc;
  wire cnt_done;

  assign startup_cyc = (startup_time_fuses_i == 2'h0) ? `STARTUP_CYC_0
    : (startup_time_fuses_i == 2'h1) ? `STARTUP_CYC_1
    : (startup_time_fuses_i == 2'h2) ? `STARTUP_CYC_2
    : `STARTUP_CYC_3;
  assign cnt_done = cnt_ff == 11'h000;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      WK_IDLE: begin
        // R5 first watchdog sample
        if (sleep_deep_i & wdt_tick_i & wake_low) begin
          nxt_state = WK_CHECK;
        end
      end
      WK_CHECK: begin
        if (~sleep_deep_i) begin
          nxt_state = WK_IDLE;
        end else if (wdt_tick_i) begin
          // R5 second sample confirms the level
          if (wake_low) begin
            nxt_state = WK_START;
            nxt_cnt = startup_cyc;
          end else begin
            nxt_state = WK_IDLE;
          end
        end
      end
      WK_START: begin
        // R6 wake runs to end of start-up
        if (cnt_done) begin
          nxt_state = WK_IDLE;
        end else begin
          nxt_cnt = cnt_ff - 11'h001;
        end
      end
      default: begin
        nxt_state = WK_IDLE;
        nxt_cnt = 11'h000;
      end
    endcase
  end

  // R6 wake held until sleep is left
  // R7 wake stays even if the level vanished
  assign nxt_wake = (nxt_state == WK_START)
    | (wake_ff & sleep_deep_i);

  // ----------------------------------------------------------------
  // flip-flops
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sense_ctrl_ff <= `SENSE_CTRL_RST;
      enable_ctrl_ff <= `ENABLE_CTRL_RST;
    end else begin
      sense_ctrl_ff <= nxt_sense_ctrl;
      enable_ctrl_ff <= nxt_enable_ctrl;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_ff <= 2'h0;
    end else begin
      pend_ff <= nxt_pend;
    end
  end

  // R9 pins sampled before edge compare
  // R20 previous sample kept for compare
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      samp_ff <= 2'h3;
      prev_ff <= 2'h3;
    end else if (io_clk_run_i) begin
      samp_ff <= {ext_irq_line_one_i, ext_irq_line_zero_i};
      prev_ff <= samp_ff;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
    end else begin
      ack_ff <= bus_req;
      rdata_ff <= nxt_rdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_zero_ff <= 1'b0;
      req_one_ff <= 1'b0;
    end else begin
      req_zero_ff <= nxt_req_zero;
      req_one_ff <= nxt_req_one;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= WK_IDLE;
      cnt_ff <= 11'h000;
      wake_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      wake_ff <= nxt_wake;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;
  assign irq_req_zero_o = req_zero_ff;
  assign irq_req_one_o = req_one_ff;
  assign wake_o = wake_ff;

endmodule

`default_nettype wire

// ### core/ext_irq_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef EXT_IRQ_MAP_SVH
`define EXT_IRQ_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets on the wishbone word bus
// ----------------------------------------------------------------
`define OFS_SENSE_CTRL 8'h00
`define OFS_ENABLE_CTRL 8'h04
`define OFS_PENDING 8'h08
`define OFS_STATUS 8'h0C

// ----------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------
`define SENSE_CTRL_RST 8'h00
`define ENABLE_CTRL_RST 8'h00
`define PENDING_RST 8'h00
`define ENABLE_CTRL_MASK 8'hC0

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BIT_LINE_ONE 7
`define BIT_LINE_ZERO 6
`define SENSE_ONE_LSB 2
`define SENSE_ZERO_LSB 0
`define STAT_PIN_ZERO 0
`define STAT_PIN_ONE 1
`define STAT_WAKE 2

// ----------------------------------------------------------------
// wake start-up counts in clk_i cycles, one per fuse setting
// ----------------------------------------------------------------
`define STARTUP_CYC_0 11'h010
`define STARTUP_CYC_1 11'h040
`define STARTUP_CYC_2 11'h100
`define STARTUP_CYC_3 11'h400

`endif

// ### core/ext_irq_pkg.sv
// types shared by the external pin interrupt block
package ext_irq_pkg;

  typedef enum logic [1:0] {
    SENSE_LOW,
    SENSE_ANY,
    SENSE_FALL,
    SENSE_RISE
  } sense_mode_t;

  typedef enum logic [1:0] {
    WK_IDLE,
    WK_CHECK,
    WK_START
  } wake_state_t;

endpackage

// ### bench/ext_irq_monitor.sv
// port assertions for the external pin interrupt block
`timescale 1ns/1ps
`default_nettype none
`include "ext_irq_map.svh"
module ext_irq_monitor
  import ext_irq_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic ext_irq_line_zero_i,
  input wire logic ext_irq_line_one_i,
  input wire logic gie_i,
  input wire logic io_clk_run_i,
  input wire logic sleep_deep_i,
  input wire logic wdt_tick_i,
  input wire logic irq_req_zero_o,
  input wire logic irq_req_one_o,
  input wire logic wake_o
);
  // ----
  // shadow of written sense and enable bits
  // ----
  logic [3:0] sense_ff;
  logic [1:0] en_ff;
  wire logic wr_take = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o
    & wb_sel_i[0];
  always_ff @(posedge clk_i) begin
    if (rst_i) sense_ff <= 4'h0;
    else if (wr_take && wb_adr_i == `OFS_SENSE_CTRL) sense_ff <= wb_dat_i[3:0];
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) en_ff <= 2'h0;
    else if (wr_take && wb_adr_i == `OFS_ENABLE_CTRL) en_ff <= wb_dat_i[7:6];
  end
  // ----
  // assertions
  // ----
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence fall_zero_s;
    sense_ff[1:0] == SENSE_FALL && $fell(ext_irq_line_zero_i)
      && io_clk_run_i && en_ff[0] && gie_i;
  endsequence
  sequence rise_one_s;
    sense_ff[3:2] == SENSE_RISE && $rose(ext_irq_line_one_i)
      && io_clk_run_i && en_ff[1] && gie_i;
  endsequence
  bus_answer_a:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
      |=> wb_ack_o ##1 !wb_ack_o) else $error("bad ack pulse");
  req_gie_a:
    assert property (irq_req_zero_o || irq_req_one_o |-> $past(gie_i))
    else $error("request without gie");
  req_enable_a:
    assert property (irq_req_zero_o |-> $past(en_ff[0]))
    else $error("line zero request while disabled");
  req_enable_one_a:
    assert property (irq_req_one_o |-> $past(en_ff[1]))
    else $error("line one request while disabled");
  level_hold_a:
    assert property (sense_ff[1:0] == SENSE_LOW && en_ff[0] && gie_i
      && !ext_irq_line_zero_i && !sleep_deep_i && !wake_o |=> irq_req_zero_o)
    else $error("low level lost");
  fall_zero_a:
    assert property (fall_zero_s |-> ##[2:4] irq_req_zero_o)
    else $error("falling edge missed");
  rise_one_a:
    assert property (rise_one_s |-> ##[2:4] irq_req_one_o)
    else $error("rising edge missed");
  wake_cause_a:
    assert property ($rose(wake_o) |-> $past(sleep_deep_i)
      && ($past(wdt_tick_i) || $past(wdt_tick_i, 2))) else $error("bad wake");
  wake_hold_a:
    assert property (wake_o && sleep_deep_i |=> wake_o) else $error("wake lost");
endmodule
`default_nettype wire

// ### bench/pin_source.sv
// model of the sources driving the two interrupt pins
`timescale 1ns/1ps
`default_nettype none
module pin_source (
  input wire logic clk_i,
  input wire logic [1:0] lvl_i,
  input wire logic slow_i,
  output logic [1:0] pin_o
);
  // ----
  // pin drivers, prompt or one cycle late
  // ----
  logic [1:0] dly_ff = 2'h3;
  logic [1:0] pin_ff = 2'h3;
  always_ff @(posedge clk_i) begin
    dly_ff <= lvl_i;
    pin_ff <= slow_i ? dly_ff : lvl_i;
  end
  assign pin_o = pin_ff;
endmodule
`default_nettype wire

// ### bench/external_pin_interrupts_tb.sv
// self-checking bench for the external pin interrupt block
`timescale 1ns/1ps
`default_nettype none
`include "ext_irq_map.svh"
module external_pin_interrupts_tb
  import ext_irq_pkg::*;
;
  logic clk_i = 1'h0, rst_i = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0;
  logic gie = 1'h0, io = 1'h1, v0 = 1'h0, v1 = 1'h0, slp = 1'h0;
  logic tick = 1'h0, slow = 1'h0;
  logic [1:0] fz = 2'h0;
  logic [3:0] sel = 4'hF;
  logic [7:0] adr = 8'h00, d;
  logic [31:0] dat = 32'h0, q;
  logic [1:0] lvl = 2'h3, s, n, e;
  wire logic [1:0] pin;
  wire logic ack, req0, req1, wake;
  wire logic [31:0] rdat;
  int errors = 0;
  int compares = 0;
  initial forever #12.5 clk_i = ~clk_i;
  external_pin_interrupts i_dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .ext_irq_line_zero_i(pin[0]), .ext_irq_line_one_i(pin[1]),
    .gie_i(gie), .io_clk_run_i(io), .vec_enter_zero_i(v0),
    .vec_enter_one_i(v1), .sleep_deep_i(slp), .wdt_tick_i(tick),
    .startup_time_fuses_i(fz), .irq_req_zero_o(req0),
    .irq_req_one_o(req1), .wake_o(wake));
  pin_source i_src (.clk_i(clk_i), .lvl_i(lvl), .slow_i(slow), .pin_o(pin));
  // ----
  // bus and checking tasks
  // ----
  task automatic check(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] x);
    int k;
    {cyc, stb, we, adr, dat} <= {2'h3, w, a, 24'h0, x};
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'h1 && k < 16);
    q = rdat;
    {cyc, stb} <= 2'h0;
    @(posedge clk_i);
    if (k >= 16) check("ack", 32'h0, 32'h1);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, exp);
    xfer(a, 1'h0, 8'h00);
    check(nm, q, {24'h0, exp});
  endtask
  task automatic wait_cyc(input int c);
    repeat (c) @(posedge clk_i);
  endtask
  task automatic pulse_tick();
    tick <= 1'h1;
    wait_cyc(1);
    tick <= 1'h0;
    wait_cyc(3);
  endtask
  function automatic logic hit(input logic [1:0] m, input logic o, nw);
    case (m)
      SENSE_ANY: return o != nw;
      SENSE_FALL: return o & ~nw;
      SENSE_RISE: return ~o & nw;
      default: return 1'h0;
    endcase
  endfunction
  // start-up length in clock cycles for a fuse setting
  function automatic int su_cyc(input logic [1:0] f);
    case (f)
      2'h0: return `STARTUP_CYC_0;
      2'h1: return `STARTUP_CYC_1;
      2'h2: return `STARTUP_CYC_2;
      default: return `STARTUP_CYC_3;
    endcase
  endfunction
  // ----
  // scenarios
  // ----
  initial begin
    void'($urandom(93));
    wait_cyc(2);
    rst_i <= 1'h0;
    wait_cyc(1);
    rd("sense", `OFS_SENSE_CTRL, 8'h00);
    rd("pending", `OFS_PENDING, 8'h00);
    xfer(`OFS_ENABLE_CTRL, 1'h1, 8'hFF);
    rd("enable", `OFS_ENABLE_CTRL, 8'hC0);
    // a write without the low byte lane must not land
    sel <= 4'hE;
    xfer(`OFS_ENABLE_CTRL, 1'h1, 8'h00);
    sel <= 4'hF;
    rd("enable", `OFS_ENABLE_CTRL, 8'hC0);
    xfer(8'h10, 1'h1, 8'hFF);
    rd("unmapped", 8'h10, 8'h00);
    gie <= 1'h1;
    for (int m = 1; m < 4; m++) begin
      for (int r = 0; r < 2; r++) begin
        d = {4'($urandom), 2'(m), 2'(m)};
        s = r ? 2'($urandom) : {2{m != 3}};
        n = r ? 2'($urandom) : ~s;
        slow <= 1'($urandom);
        xfer(`OFS_SENSE_CTRL, 1'h1, d);
        rd("sense", `OFS_SENSE_CTRL, d);
        lvl <= s;
        wait_cyc(6);
        xfer(`OFS_PENDING, 1'h1, 8'hC0);
        lvl <= n;
        wait_cyc(6);
        e = {hit(2'(m), s[1], n[1]), hit(2'(m), s[0], n[0])};
        rd("pending", `OFS_PENDING, {e, 6'h00});
        rd("status", `OFS_STATUS, {6'h00, n});
        check("request", {req1, req0}, e);
        xfer(`OFS_PENDING, 1'h1, 8'h00);
        rd("pending", `OFS_PENDING, {e, 6'h00});
        xfer(`OFS_PENDING, 1'h1, 8'hC0);
        rd("pending", `OFS_PENDING, 8'h00);
      end
    end
    xfer(`OFS_SENSE_CTRL, 1'h1, 8'h0A);
    lvl <= 2'h3;
    wait_cyc(6);
    xfer(`OFS_PENDING, 1'h1, 8'hC0);
    {slow, lvl} <= 3'h0;
    wait_cyc(2);
    lvl <= 2'h3;
    wait_cyc(6);
    v1 <= 1'h1;
    wait_cyc(1);
    v1 <= 1'h0;
    rd("pending", `OFS_PENDING, 8'h40);
    v0 <= 1'h1;
    wait_cyc(1);
    v0 <= 1'h0;
    rd("pending", `OFS_PENDING, 8'h00);
    // edges ignored while the io clock is stopped
    xfer(`OFS_SENSE_CTRL, 1'h1, 8'h05);
    {io, lvl} <= 3'h0;
    wait_cyc(4);
    lvl <= 2'h3;
    wait_cyc(4);
    io <= 1'h1;
    wait_cyc(4);
    rd("pending", `OFS_PENDING, 8'h00);
    // leave both flags set, then level mode must hide them
    lvl <= 2'h0;
    wait_cyc(6);
    rd("pending", `OFS_PENDING, 8'hC0);
    xfer(`OFS_SENSE_CTRL, 1'h1, 8'h00);
    wait_cyc(20);
    check("request", {req1, req0}, 2'h3);
    rd("pending", `OFS_PENDING, 8'h00);
    gie <= 1'h0;
    wait_cyc(2);
    check("request", {req1, req0}, 2'h0);
    gie <= 1'h1;
    xfer(`OFS_ENABLE_CTRL, 1'h1, 8'h40);
    wait_cyc(2);
    check("request", {req1, req0}, 2'h1);
    // a level seen only once must not wake
    slp <= 1'h1;
    fz <= 2'($urandom);
    pulse_tick();
    lvl <= 2'h3;
    wait_cyc(3);
    pulse_tick();
    check("wake", wake, 1'h0);
    lvl <= 2'h2;
    wait_cyc(3);
    pulse_tick();
    pulse_tick();
    check("wake", wake, 1'h1);
    // sleep left early: wake lasts the start-up count plus one cycle
    {slp, lvl} <= 3'h3;
    wait_cyc(su_cyc(fz) - 2);
    check("wake", wake, 1'h1);
    wait_cyc(1);
    check("wake", wake, 1'h0);
    check("request", req0, 1'h0);
    conclude();
  end
  initial begin
    wait_cyc(20000);
    errors++;
    conclude();
  end
endmodule
bind external_pin_interrupts ext_irq_monitor i_mon (.clk_i(clk_i),
  .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
  .ext_irq_line_zero_i(ext_irq_line_zero_i),
  .ext_irq_line_one_i(ext_irq_line_one_i), .gie_i(gie_i),
  .io_clk_run_i(io_clk_run_i), .sleep_deep_i(sleep_deep_i),
  .wdt_tick_i(wdt_tick_i), .irq_req_zero_o(irq_req_zero_o),
  .irq_req_one_o(irq_req_one_o), .wake_o(wake_o));
`default_nettype wire
